// *** inc/redriver_pkg.sv ***
// Register map, field positions, reset values and timing of the lane config block.
// Assumes a single 250 MHz register clock.
package redriver_pkg;
   // Byte offsets reached through the SMBus command byte
   localparam logic [7:0] OFF_A0_DEEMPH = 8'h2e;
   localparam logic [7:0] OFF_A0_THRESH = 8'h2f;
   localparam logic [7:0] OFF_A1_IDLE   = 8'h32;
   localparam logic [7:0] OFF_A1_EQ     = 8'h33;
   localparam logic [7:0] OFF_A1_SWING  = 8'h34;
   localparam logic [7:0] OFF_A1_DEEMPH = 8'h35;
   localparam logic [7:0] OFF_A1_THRESH = 8'h36;
   // Reset values; de-emphasis keeps only its writable low five bits
   localparam logic [4:0] RST_DEEMPH = 5'h02;
   localparam logic [7:0] RST_THRESH = 8'h00;
   localparam logic [7:0] RST_IDLE   = 8'h00;
   localparam logic [7:0] RST_EQ     = 8'h2f;
   localparam logic [7:0] RST_SWING  = 8'had;
   // Field positions
   localparam int DET_BIT       = 7;
   localparam int RATE_HI       = 6;
   localparam int RATE_LO       = 5;
   localparam int IDLE_AUTO_BIT = 5;
   localparam int IDLE_MUTE_BIT = 4;
   localparam int PD_HI         = 3;
   localparam int PD_LO         = 2;
   localparam int SCP_BIT       = 7;
   localparam int GEN12_BIT     = 6;
   // Far receiver probe codes
   localparam logic [1:0] PD_HIZ     = 2'h0;
   localparam logic [1:0] PD_LIMITED = 2'h1;
   localparam logic [1:0] PD_ENDLESS = 2'h2;
   localparam logic [1:0] PD_FIXED   = 2'h3;
   // Default SMBus slave address, arbitrary
   localparam logic [6:0] SMB_ADDR_DEF = 7'h18;
   // Probe timing
   localparam int CLK_KHZ          = 250000;
   localparam int PROBE_PERIOD_MS  = 12;
   localparam int PROBE_PERIOD_CYC = PROBE_PERIOD_MS * CLK_KHZ;
   localparam int PROBE_LIMIT      = 50;

   typedef enum {S_IDLE, S_RX, S_RX_END, S_ACK, S_TX, S_TX_END, S_MACK, S_TX_LOAD} smb_state_t;
   typedef enum {PH_ADDR, PH_CMD, PH_DATA} smb_phase_t;
   typedef enum {PS_HIZ, PS_WAIT, PS_FOUND, PS_GAVE_UP, PS_FIXED} probe_state_t;
endpackage

// *** inc/probe_if.sv ***
// Link between the register block and the far receiver probe sequencer.
// Both ends run on the register clock.
`timescale 1ns/1ps
interface probe_if;
   logic [1:0] code;
   logic       sensed;
   logic       strobe;
   logic       term50;
   logic       detected;
   modport seq (input code, input sensed, output strobe, output term50, output detected);
   modport ctl (output code, output sensed, input strobe, input term50, input detected);
endinterface

// *** src/sync2.sv ***
// Two-flop synchroniser for a vector of pin levels.
// Each bit is a slow level; no bus coherency is promised.
`timescale 1ns/1ps
module sync2 #(
   parameter int W = 1
) (
   input  wire logic         clock_in,
   input  wire logic         rst_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] meta_reg;

   // First stage feeds only the second
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         meta_reg <= '0;
         q_out    <= '0;
      end else begin
         meta_reg <= d_in;
         q_out    <= meta_reg;
      end
   end
endmodule

// *** src/far_receiver_probe_seq.sv ***
// Far receiver probe sequencer for one lane: periodic probes and termination.
// Assumes sensed is already synchronised and stays high once a receiver answers.
`timescale 1ns/1ps
module far_receiver_probe_seq import redriver_pkg::*; #(
   parameter int PERIOD_CYC = PROBE_PERIOD_CYC,
   parameter int LIMIT      = PROBE_LIMIT
) (
   input  wire logic clock_in,
   input  wire logic rst_in,
   probe_if.seq      p
);
   localparam int CW = $clog2(PERIOD_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(PERIOD_CYC - 1);
   localparam logic [6:0] LIM = 7'(LIMIT);

   probe_state_t st_reg, st_next;
   logic [CW-1:0] cnt_reg, cnt_next;
   logic [6:0] tries_reg, tries_next;
   logic [1:0] prev_reg;
   logic strobe_reg, strobe_next;
   logic term_reg, term_next;
   logic det_reg, det_next;

   if (PERIOD_CYC < 2 || LIMIT < 1 || LIMIT > 127) begin : g_chk
      $error("probe period or limit out of range");
   end

   // Any change of code restarts the sequence from scratch
   always_comb begin
      st_next     = st_reg;
      cnt_next    = cnt_reg;
      tries_next  = tries_reg;
      strobe_next = 1'b0;
      if (p.code != prev_reg) begin
         cnt_next   = '0;
         tries_next = '0;
         unique case (p.code)
            PD_HIZ:   st_next = PS_HIZ; // R11
            PD_FIXED: st_next = PS_FIXED; // R11
            default:  st_next = PS_WAIT;
         endcase
      end else begin
         unique case (st_reg)
            PS_WAIT: begin
               if (p.sensed) begin
                  st_next = PS_FOUND; // R12 R13
               end else if (cnt_reg == LAST) begin
                  cnt_next = '0;
                  // Last probe gets a full period to answer before giving up
                  if (p.code == PD_LIMITED && tries_reg == LIM) begin
                     st_next = PS_GAVE_UP; // R12
                  end else begin
                     strobe_next = 1'b1; // R12 R13
                     tries_next  = (tries_reg == LIM) ? tries_reg : tries_reg + 7'h01;
                  end
               end else begin
                  cnt_next = cnt_reg + CW'(1);
               end
            end
            PS_HIZ, PS_FOUND, PS_GAVE_UP, PS_FIXED: ;
         endcase
      end
      term_next = (st_next == PS_FOUND) || (st_next == PS_FIXED);
      det_next  = (st_next == PS_FOUND);
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         st_reg     <= PS_HIZ;
         cnt_reg    <= '0;
         tries_reg  <= '0;
         prev_reg   <= PD_HIZ;
         strobe_reg <= 1'b0;
         term_reg   <= 1'b0;
         det_reg    <= 1'b0;
      end else begin
         st_reg     <= st_next;
         cnt_reg    <= cnt_next;
         tries_reg  <= tries_next;
         prev_reg   <= p.code;
         strobe_reg <= strobe_next;
         term_reg   <= term_next;
         det_reg    <= det_next;
      end
   end

   assign p.strobe   = strobe_reg;
   assign p.term50   = term_reg;
   assign p.detected = det_reg;

   property p_limit;
      @(posedge clock_in) disable iff (rst_in) tries_reg <= LIM;
   endproperty
   a_limit: assert property (p_limit) else $error("too many probes"); // R12

   property p_found;
      @(posedge clock_in) disable iff (rst_in)
         (st_reg == PS_WAIT && p.sensed && p.code == prev_reg) |=> (p.term50 && p.detected);
   endproperty
   a_found: assert property (p_found) else $error("detection not taken"); // R13

   property p_hiz;
      @(posedge clock_in) disable iff (rst_in) (p.code == PD_HIZ) [*2] |-> !p.term50;
   endproperty
   a_hiz: assert property (p_hiz) else $error("termination on in high-z code"); // R11
endmodule

// *** src/redriver_channel_config_regs.sv ***
// Lane pair configuration registers behind a byte SMBus slave.
// Assumes SCL/SDA and analog status pins are asynchronous; SDA is open drain.
//
// What this block does
// R1 - Bit7 reports far receiver detected per lane
// R2 - Bits 6:5 report detected link rate
// R3 - Rate status valid only in automatic mode
// R4 - De-emphasis code bits 2:0, default 010
// R5 - Host keeps swing reserved bits at 101
// R6 - Threshold bits 3:2 pick assert level
// R7 - Threshold bits 1:0 pick deassert level
// R8 - Written thresholds override threshold strap pin
// R9 - Idle bit5 selects automatic idle detect
// R10 - Manual bit4 mutes output when automatic off
// R11 - Probe code 00 high-z, 11 fixed 50 ohm
// R12 - Code 01 probes 50 times every 12 ms
// R13 - Code 10 probes every 12 ms until found
// R14 - Written probe code overrides probe strap pin
// R15 - Eight-bit equalizer boost, reset 2f
// R16 - Swing bit7 short protection, reset ad
// R17 - Swing bit6 selects gen1/2, overrides strap
// R18 - Swing bits 2:0 amplitude, default 101
// R19 - Writes touch writable fields; status reads live
`timescale 1ns/1ps
module redriver_channel_config_regs import redriver_pkg::*; #(
   parameter logic [6:0] SMB_ADDR  = SMB_ADDR_DEF,
   parameter int         PROBE_CYC = PROBE_PERIOD_CYC
) (
   input  wire logic       clock_in,
   input  wire logic       rst_in,
   input  wire logic       smb_scl_in,
   input  wire logic       smb_sda_in,
   output logic            smb_sda_out,
   output logic            smb_sda_oe_out,
   input  wire logic       mode_pin_auto_in,
   input  wire logic [1:0] rate_detect_a0_in,
   input  wire logic [1:0] rate_detect_a1_in,
   input  wire logic       far_end_a0_in,
   input  wire logic       far_end_a1_in,
   input  wire logic [3:0] signal_detect_level_pin_in,
   input  wire logic [1:0] far_receiver_probe_pin_in,
   input  wire logic       mode_gen12_pin_in,
   output logic [2:0]      deemphasis_level_a0_out,
   output logic [2:0]      deemphasis_level_a1_out,
   output logic [3:0]      sd_level_a0_out,
   output logic [3:0]      sd_level_a1_out,
   output logic            auto_idle_a1_out,
   output logic            output_mute_a1_out,
   output logic            term_50_a1_out,
   output logic            far_receiver_probe_a1_out,
   output logic [7:0]      eq_boost_a1_out,
   output logic            short_protect_a1_out,
   output logic            gen12_a1_out,
   output logic [2:0]      output_swing_a1_out
);
   probe_if pi ();

   logic [15:0] pins_s;
   logic scl_s, sda_s, mode_auto_s, far_a0_s, far_a1_s, gen12_pin_s;
   logic [1:0] rate_a0_s, rate_a1_s, rx_pin_s;
   logic [3:0] sd_pin_s;
   logic scl_d_reg, sda_d_reg;
   logic scl_rise, scl_fall, start, stop;

   smb_state_t st_reg, st_next;
   smb_phase_t ph_reg, ph_next;
   logic [2:0] bit_reg, bit_next;
   logic [7:0] sh_reg, sh_next;
   logic [7:0] ptr_reg, ptr_next;
   logic rw_reg, rw_next;
   logic oe_reg, oe_next;
   logic wr_en, load;
   logic [7:0] rd_data;

   logic [4:0] dem_a0_reg, dem_a0_next, dem_a1_reg, dem_a1_next;
   logic [7:0] thr_a0_reg, thr_a0_next, thr_a1_reg, thr_a1_next;
   logic [7:0] idle_a1_reg, idle_a1_next, eq_a1_reg, eq_a1_next, swing_a1_reg, swing_a1_next;
   logic thr_a0_wr, thr_a0_wr_next, thr_a1_wr, thr_a1_wr_next;
   logic idle_wr, idle_wr_next, swing_wr, swing_wr_next;
   logic [3:0] sd_a0_reg, sd_a0_next, sd_a1_reg, sd_a1_next;
   logic mute_reg, mute_next, gen12_reg, gen12_next;

   // All outside levels pass two flops before use
   sync2 #(.W(16)) u_sync (
      .clock_in (clock_in),
      .rst_in   (rst_in),
      .d_in     ({smb_scl_in, smb_sda_in, mode_pin_auto_in, rate_detect_a0_in, rate_detect_a1_in,
                  far_end_a0_in, far_end_a1_in, signal_detect_level_pin_in, far_receiver_probe_pin_in,
                  mode_gen12_pin_in}),
      .q_out    (pins_s)
   );
   assign {scl_s, sda_s, mode_auto_s, rate_a0_s, rate_a1_s, far_a0_s, far_a1_s, sd_pin_s, rx_pin_s,
           gen12_pin_s} = pins_s;

   far_receiver_probe_seq #(.PERIOD_CYC(PROBE_CYC), .LIMIT(PROBE_LIMIT)) u_probe (
      .clock_in (clock_in),
      .rst_in   (rst_in),
      .p        (pi.seq)
   );
   // Probe code follows the strap until the host writes it
   assign pi.code   = idle_wr ? idle_a1_reg[PD_HI:PD_LO] : rx_pin_s; // R14
   assign pi.sensed = far_a1_s;

   // Bus events from the synchronised lines
   assign scl_rise = scl_s & ~scl_d_reg;
   assign scl_fall = ~scl_s & scl_d_reg;
   assign start    = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   assign stop     = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

   // Read mux; status bits are live, never stored
   always_comb begin
      unique case (ptr_reg)
         OFF_A0_DEEMPH: rd_data = {far_a0_s, mode_auto_s ? rate_a0_s : 2'h0, dem_a0_reg}; // R1 R2 R3 R19
         OFF_A0_THRESH: rd_data = thr_a0_reg;
         OFF_A1_IDLE:   rd_data = idle_a1_reg;
         OFF_A1_EQ:     rd_data = eq_a1_reg;
         OFF_A1_SWING:  rd_data = swing_a1_reg;
         OFF_A1_DEEMPH: rd_data = {pi.detected, mode_auto_s ? rate_a1_s : 2'h0, dem_a1_reg}; // R1 R2 R3 R19
         OFF_A1_THRESH: rd_data = thr_a1_reg;
         default:       rd_data = 8'h00;
      endcase
   end

   // Byte slave: write = addr, command, data...; read returns from the pointer
   always_comb begin
      st_next  = st_reg;
      ph_next  = ph_reg;
      bit_next = bit_reg;
      sh_next  = sh_reg;
      ptr_next = ptr_reg;
      rw_next  = rw_reg;
      oe_next  = oe_reg;
      wr_en    = 1'b0;
      load     = 1'b0;
      if (start) begin
         st_next  = S_RX;
         ph_next  = PH_ADDR;
         bit_next = 3'h0;
         oe_next  = 1'b0;
      end else if (stop) begin
         st_next = S_IDLE;
         oe_next = 1'b0;
      end else begin
         unique case (st_reg)
            S_IDLE: ;
            S_RX: if (scl_rise) begin
               sh_next  = {sh_reg[6:0], sda_s};
               bit_next = bit_reg + 3'h1;
               if (bit_reg == 3'h7) st_next = S_RX_END;
            end
            S_RX_END: if (scl_fall) begin
               st_next = S_ACK;
               oe_next = 1'b1;
               unique case (ph_reg)
                  PH_ADDR: if (sh_reg[7:1] != SMB_ADDR) begin
                     st_next = S_IDLE;
                     oe_next = 1'b0;
                  end else begin
                     rw_next = sh_reg[0];
                  end
                  PH_CMD: ptr_next = sh_reg;
                  PH_DATA: begin
                     wr_en    = 1'b1;
                     ptr_next = ptr_reg + 8'h01;
                  end
               endcase
            end
            S_ACK: if (scl_fall) begin
               if (ph_reg == PH_ADDR && rw_reg) begin
                  load = 1'b1;
               end else begin
                  st_next  = S_RX;
                  bit_next = 3'h0;
                  oe_next  = 1'b0;
                  ph_next  = (ph_reg == PH_ADDR) ? PH_CMD : PH_DATA;
               end
            end
            S_TX: if (scl_rise) begin
               bit_next = bit_reg + 3'h1;
               if (bit_reg == 3'h7) st_next = S_TX_END;
            end else if (scl_fall) begin
               sh_next = {sh_reg[6:0], 1'b0};
               oe_next = ~sh_reg[6];
            end
            S_TX_END: if (scl_fall) begin
               oe_next = 1'b0;
               st_next = S_MACK;
            end
            S_MACK: if (scl_rise) st_next = sda_s ? S_IDLE : S_TX_LOAD;
            S_TX_LOAD: if (scl_fall) load = 1'b1;
         endcase
      end
      if (load) begin
         sh_next  = rd_data;
         ptr_next = ptr_reg + 8'h01;
         oe_next  = ~rd_data[7];
         bit_next = 3'h0;
         st_next  = S_TX;
      end
   end

   // Register writes; status bits of the de-emphasis registers are not stored
   always_comb begin
      dem_a0_next    = dem_a0_reg;
      dem_a1_next    = dem_a1_reg;
      thr_a0_next    = thr_a0_reg;
      thr_a1_next    = thr_a1_reg;
      idle_a1_next   = idle_a1_reg;
      eq_a1_next     = eq_a1_reg;
      swing_a1_next  = swing_a1_reg;
      thr_a0_wr_next = thr_a0_wr;
      thr_a1_wr_next = thr_a1_wr;
      idle_wr_next   = idle_wr;
      swing_wr_next  = swing_wr;
      if (wr_en) begin
         unique case (ptr_reg)
            OFF_A0_DEEMPH: dem_a0_next = sh_reg[4:0]; // R4 R19
            OFF_A1_DEEMPH: dem_a1_next = sh_reg[4:0]; // R4 R19
            OFF_A0_THRESH: begin
               thr_a0_next    = sh_reg; // R6 R7
               thr_a0_wr_next = 1'b1;
            end
            OFF_A1_THRESH: begin
               thr_a1_next    = sh_reg; // R6 R7
               thr_a1_wr_next = 1'b1;
            end
            OFF_A1_IDLE: begin
               idle_a1_next = sh_reg; // R9 R10 R11
               idle_wr_next = 1'b1;
            end
            OFF_A1_EQ: eq_a1_next = sh_reg; // R15
            OFF_A1_SWING: begin
               // Reserved pattern is the host's duty; stored as written
               swing_a1_next = sh_reg; // R5 R16 R18
               swing_wr_next = 1'b1;
            end
            default: ;
         endcase
      end
      sd_a0_next = thr_a0_wr ? thr_a0_reg[3:0] : sd_pin_s; // R8
      sd_a1_next = thr_a1_wr ? thr_a1_reg[3:0] : sd_pin_s; // R8
      mute_next  = ~idle_a1_reg[IDLE_AUTO_BIT] & idle_a1_reg[IDLE_MUTE_BIT]; // R9 R10
      gen12_next = swing_wr ? swing_a1_reg[GEN12_BIT] : gen12_pin_s; // R17
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         scl_d_reg    <= 1'b1;
         sda_d_reg    <= 1'b1;
         st_reg       <= S_IDLE;
         ph_reg       <= PH_ADDR;
         bit_reg      <= 3'h0;
         sh_reg       <= 8'h00;
         ptr_reg      <= 8'h00;
         rw_reg       <= 1'b0;
         oe_reg       <= 1'b0;
         dem_a0_reg   <= RST_DEEMPH;
         dem_a1_reg   <= RST_DEEMPH;
         thr_a0_reg   <= RST_THRESH;
         thr_a1_reg   <= RST_THRESH;
         idle_a1_reg  <= RST_IDLE;
         eq_a1_reg    <= RST_EQ;
         swing_a1_reg <= RST_SWING;
         thr_a0_wr    <= 1'b0;
         thr_a1_wr    <= 1'b0;
         idle_wr      <= 1'b0;
         swing_wr     <= 1'b0;
         sd_a0_reg    <= 4'h0;
         sd_a1_reg    <= 4'h0;
         mute_reg     <= 1'b0;
         gen12_reg    <= 1'b0;
      end else begin
         scl_d_reg    <= scl_s;
         sda_d_reg    <= sda_s;
         st_reg       <= st_next;
         ph_reg       <= ph_next;
         bit_reg      <= bit_next;
         sh_reg       <= sh_next;
         ptr_reg      <= ptr_next;
         rw_reg       <= rw_next;
         oe_reg       <= oe_next;
         dem_a0_reg   <= dem_a0_next;
         dem_a1_reg   <= dem_a1_next;
         thr_a0_reg   <= thr_a0_next;
         thr_a1_reg   <= thr_a1_next;
         idle_a1_reg  <= idle_a1_next;
         eq_a1_reg    <= eq_a1_next;
         swing_a1_reg <= swing_a1_next;
         thr_a0_wr    <= thr_a0_wr_next;
         thr_a1_wr    <= thr_a1_wr_next;
         idle_wr      <= idle_wr_next;
         swing_wr     <= swing_wr_next;
         sd_a0_reg    <= sd_a0_next;
         sd_a1_reg    <= sd_a1_next;
         mute_reg     <= mute_next;
         gen12_reg    <= gen12_next;
      end
   end

   // Open drain: only ever pulls low
   assign smb_sda_out               = 1'b0;
   assign smb_sda_oe_out            = oe_reg;
   assign deemphasis_level_a0_out   = dem_a0_reg[2:0];
   assign deemphasis_level_a1_out   = dem_a1_reg[2:0];
   assign sd_level_a0_out           = sd_a0_reg;
   assign sd_level_a1_out           = sd_a1_reg;
   assign auto_idle_a1_out          = idle_a1_reg[IDLE_AUTO_BIT];
   assign output_mute_a1_out        = mute_reg;
   assign term_50_a1_out            = pi.term50;
   assign far_receiver_probe_a1_out = pi.strobe;
   assign eq_boost_a1_out           = eq_a1_reg;
   assign short_protect_a1_out      = swing_a1_reg[SCP_BIT];
   assign gen12_a1_out              = gen12_reg;
   assign output_swing_a1_out       = swing_a1_reg[2:0];

   property p_mute;
      @(posedge clock_in) disable iff (rst_in)
         (!idle_a1_reg[IDLE_AUTO_BIT] && idle_a1_reg[IDLE_MUTE_BIT]) |=> output_mute_a1_out;
   endproperty
   a_mute: assert property (p_mute) else $error("manual mute not applied"); // R10

   property p_auto;
      @(posedge clock_in) disable iff (rst_in) idle_a1_reg[IDLE_AUTO_BIT] |=> !output_mute_a1_out;
   endproperty
   a_auto: assert property (p_auto) else $error("muted in automatic idle"); // R9

   property p_rate;
      @(posedge clock_in) disable iff (rst_in)
         (ptr_reg == OFF_A0_DEEMPH && !mode_auto_s) |-> (rd_data[RATE_HI:RATE_LO] == 2'h0);
   endproperty
   a_rate: assert property (p_rate) else $error("rate status outside auto mode"); // R3

   property p_det;
      @(posedge clock_in) disable iff (rst_in) (ptr_reg == OFF_A1_DEEMPH) |-> (rd_data[DET_BIT] == pi.detected);
   endproperty
   a_det: assert property (p_det) else $error("detect status wrong"); // R1

   property p_thr;
      @(posedge clock_in) disable iff (rst_in) thr_a1_wr |=> (sd_level_a1_out == $past(thr_a1_reg[3:0]));
   endproperty
   a_thr: assert property (p_thr) else $error("threshold strap not overridden"); // R8

   property p_gen;
      @(posedge clock_in) disable iff (rst_in) swing_wr |=> (gen12_a1_out == $past(swing_a1_reg[GEN12_BIT]));
   endproperty
   a_gen: assert property (p_gen) else $error("mode strap not overridden"); // R17

   property p_ro;
      @(posedge clock_in) disable iff (rst_in)
         (wr_en && ptr_reg == OFF_A1_DEEMPH) |=> (dem_a1_reg == $past(sh_reg[4:0]));
   endproperty
   a_ro: assert property (p_ro) else $error("de-emphasis write lost"); // R19

   property p_nack;
      @(posedge clock_in) disable iff (rst_in)
         (st_reg == S_RX_END && scl_fall && ph_reg == PH_ADDR && sh_reg[7:1] != SMB_ADDR) |=> !smb_sda_oe_out;
   endproperty
   a_nack: assert property (p_nack) else $error("foreign address acknowledged"); // R19
endmodule

// *** bench/smb_host.sv ***
// SMBus host model for the lane config block.
// Assumes a pull-up on SDA; the block pulls low on its enable.
`timescale 1ns/1ps
module smb_host import redriver_pkg::*; (
   input  wire logic clock_in,
   input  wire logic oe_in,
   output logic      scl_out,
   output wire logic sda_out
);
   logic drv = 1'b1;
   // Released SDA reads high
   assign sda_out = drv & ~oe_in;
   initial scl_out = 1'b1;
   // One quarter of a 48 ns SCL period
   task automatic ph(input logic c, input logic d);
      scl_out <= c;
      drv <= d;
      repeat (3) @(posedge clock_in);
   endtask
   // Bit is a,a; START 1,0; STOP 0,1
   task automatic cyc(input logic a, input logic b, output logic r);
      ph(1'b0, drv);
      ph(1'b0, a);
      ph(1'b1, a);
      r = sda_out;
      ph(1'b1, b);
   endtask
   // Ninth bit released, so reads end in NACK
   task automatic xfer(input logic [7:0] d, output logic [7:0] v, inout logic ok);
      logic r;
      for (int i = 7; i >= 0; i--) cyc(d[i], d[i], v[i]);
      cyc(1'b1, 1'b1, r);
      ok &= ~r;
   endtask
   task automatic xact(input logic [7:0] o, d, input logic rd, output logic [7:0] v, output logic ok);
      logic [7:0] x;
      ok = 1'b1;
      cyc(1'b1, 1'b0, x[0]);
      xfer({SMB_ADDR_DEF, 1'b0}, x, ok);
      xfer(o, x, ok);
      if (rd) begin
         cyc(1'b1, 1'b0, x[0]);
         xfer({SMB_ADDR_DEF, 1'b1}, x, ok);
      end
      xfer(rd ? 8'hff : d, v, ok);
      cyc(1'b0, 1'b1, x[0]);
   endtask
endmodule

// *** bench/tb.sv ***
// Bench: host traffic checked against a register model.
// Assumes a 20-cycle probe period.
`timescale 1ns/1ps
module tb;
   import redriver_pkg::*;
   logic       clk = 1'b0, rst = 1'b1, auto = 1'b1, fe0 = 1'b0, fe1 = 1'b0, gpin = 1'b1, det1 = 1'b0;
   logic       scl, sda, oe, ok, mute, aid, term, pulse, scp, g12;
   logic [1:0] r0 = 2'h0, r1 = 2'h0, ppin = 2'h3;
   logic [2:0] dm0, dm1, sw;
   logic [3:0] sdpin = 4'h9, sd0, sd1;
   logic [7:0] eq, v, w, mdl[int];
   int         mismatches = 0, cmp_count = 0, pulses = 0;
   smb_host smb_host_i (.clock_in(clk), .oe_in(oe), .scl_out(scl), .sda_out(sda));
   redriver_channel_config_regs #(.PROBE_CYC(20)) redriver_channel_config_regs_i (.clock_in(clk), .rst_in(rst),
      .smb_scl_in(scl), .smb_sda_in(sda), .smb_sda_out(), .smb_sda_oe_out(oe), .mode_pin_auto_in(auto),
      .rate_detect_a0_in(r0), .rate_detect_a1_in(r1), .far_end_a0_in(fe0), .far_end_a1_in(fe1),
      .signal_detect_level_pin_in(sdpin), .far_receiver_probe_pin_in(ppin), .mode_gen12_pin_in(gpin),
      .deemphasis_level_a0_out(dm0), .deemphasis_level_a1_out(dm1), .sd_level_a0_out(sd0), .sd_level_a1_out(sd1),
      .auto_idle_a1_out(aid), .output_mute_a1_out(mute), .term_50_a1_out(term), .far_receiver_probe_a1_out(pulse),
      .eq_boost_a1_out(eq), .short_protect_a1_out(scp), .gen12_a1_out(g12), .output_swing_a1_out(sw));
   // Clock, probe count and watchdog
   always #2 clk = ~clk;
   always @(posedge clk) if (pulse === 1'b1) pulses++;
   initial begin
      #200us;
      mismatches++;
      test_done();
   end
   task automatic test_done;
      if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // Status bits of de-emphasis are not storable
   task automatic wr(input logic [7:0] o, input logic [7:0] d);
      smb_host_i.xact(o, d, 1'b0, v, ok);
      chk("ack", 8'h1, {7'h0, ok});
      if (mdl.exists(o)) mdl[o] = (o == 8'h2e || o == 8'h35) ? {3'h0, d[4:0]} : d;
   endtask
   task automatic rd(input logic [7:0] o);
      logic [7:0] e;
      e = mdl.exists(o) ? mdl[o] : 8'h00;
      if (o == 8'h2e) e[7:5] = {fe0, auto ? r0 : 2'h0};
      if (o == 8'h35) e[7:5] = {det1, auto ? r1 : 2'h0};
      smb_host_i.xact(o, 8'h00, 1'b1, v, ok);
      chk("reg", e, v);
   endtask
   // Reset values, codes, overrides, then both probing codes
   initial begin
      mdl = '{8'h2e: 8'h02, 8'h2f: 8'h00, 8'h32: 8'h00, 8'h33: 8'h2f, 8'h34: 8'had, 8'h35: 8'h02, 8'h36: 8'h00};
      void'($urandom(32'h26f63d48));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (10) @(posedge clk);
      chk("straps", {2'h0, gpin, 1'b1, sdpin}, {2'h0, g12, term, sd1});
      foreach (mdl[o]) rd(o[7:0]);
      wr(8'h30, 8'h55);
      rd(8'h30);
      // Foreign address must see no acknowledge
      ok = 1'b1;
      smb_host_i.cyc(1'b1, 1'b0, w[0]);
      smb_host_i.xfer({~SMB_ADDR_DEF, 1'b0}, w, ok);
      smb_host_i.cyc(1'b0, 1'b1, w[0]);
      chk("nack", 8'h0, {7'h0, ok});
      for (int c = 0; c < 8; c++) begin
         {auto, fe0, r0, r1} <= {c[0], c[1], c[1], c[1] | c[2], c[2], c[2] | c[0]};
         wr(c[0] ? 8'h2e : 8'h35, {3'($urandom), 2'h0, 3'(c)});
         chk("deemph", 8'(c), {5'h0, c[0] ? dm0 : dm1});
         rd(c[0] ? 8'h2e : 8'h35);
      end
      w = 8'($urandom) & 8'h0f;
      wr(8'h36, w);
      chk("thresh", {w[3:0], sdpin}, {sd1, sd0});
      w = 8'($urandom);
      wr(8'h33, w);
      chk("eq", w, eq);
      w = {1'($urandom), ~gpin, 3'h5, 3'($urandom)};
      wr(8'h34, w);
      chk("swing", w, {scp, g12, 3'h5, sw});
      wr(8'h32, 8'h10);
      chk("idle", 8'h2, {5'h0, aid, mute, term});
      wr(8'h32, 8'h3c);
      chk("idle", 8'h5, {5'h0, aid, mute, term});
      pulses = 0;
      wr(8'h32, 8'h04);
      repeat (1100) @(posedge clk);
      chk("limited", 8'd50, {term, 7'(pulses)});
      pulses = 0;
      wr(8'h32, 8'h08);
      repeat (1100) @(posedge clk);
      chk("endless", 8'h1, {7'h0, pulses > 50});
      {fe1, det1} <= 2'h3;
      repeat (30) @(posedge clk);
      chk("found", 8'h1, {7'h0, term});
      rd(8'h35);
      test_done();
   end
endmodule
